// ### pmrc_pkg.sv
// power mode and reset control: shared constants, register map, enums
// assumes a 250 MHz pclk and an apb master in the same domain
package pmrc_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_PMU_CTRL    = 12'h000;
	localparam logic [11:0] OFS_SYS_CTRL    = 12'h004;
	localparam logic [11:0] OFS_POR_PIN     = 12'h008;
	localparam logic [11:0] OFS_POR_TIME    = 12'h00c;
	localparam logic [11:0] OFS_CPU_SCR     = 12'h010;
	localparam logic [11:0] OFS_CPU_AIRCR   = 12'h014;
	localparam logic [11:0] OFS_RETAIN      = 12'h018;
	localparam logic [11:0] OFS_STATUS      = 12'h01c;
	// power_mgmt_control fields
	localparam int PMU_PER_OFF_BIT   = 1;
	localparam int PMU_RAD_OFF_BIT   = 2;
	localparam int PMU_RST_WAKE_BIT  = 3;
	localparam int PMU_RAM_RET_LSB   = 8;
	localparam int PMU_RAM_RET_W     = 4;
	localparam logic [31:0] PMU_CTRL_RESET = 32'h0000_0000;
	// system_control fields
	localparam int SYS_SOFT_RST_BIT  = 15;
	localparam int SYS_CODE_RET_BIT  = 0;
	// cpu_system_control deep sleep bit
	localparam int DEEP_SLEEP_BIT    = 2;
	localparam logic [31:0] CPU_RESET_KEY = 32'h05fa_0004;
	// por pin field
	localparam int PIN_SEL_W         = 6;
	localparam int POR_POL_BIT       = 7;
	localparam int POR_TIME_W        = 7;
	localparam logic [6:0] POR_TIME_RESET = 7'h18;
	localparam int PRESCALE_W        = 12;
	localparam int RAM_CELLS         = 4;
	localparam int SOFT_RST_CYCLES   = 16;
	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_SLEEP,
		ST_EXT_SLEEP,
		ST_DEEP_SLEEP,
		ST_WAKE,
		ST_MIRROR
	} pmode_t;
endpackage

// ### power_mode_reset_control.sv
// power_mode_reset_control: power mode sequencer, domain gating and reset generation
// assumes apb master on pclk; reset pad, gpio and rc clock tick arrive asynchronously
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control
	import pmrc_pkg::*;
#(
	parameter int GPIO_PINS = 32
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// cpu side
	input  wire logic                  cpu_sleep_req,
	input  wire logic                  wake_irq,
	input  wire logic                  mirror_done,
	// external reset sources
	input  wire logic                  reset_pad,
	input  wire logic [GPIO_PINS-1:0]  gpio_in,
	input  wire logic                  low_freq_rc_clock,
	// domain and analog controls
	output logic                       system_power_domain,
	output logic                       peripheral_power_domain,
	output logic                       radio_power_domain,
	output logic                       debug_power_domain,
	output logic [RAM_CELLS-1:0]       ram_cell_domains,
	output logic                       analog_enable,
	output logic                       rc_clock_enable,
	output logic                       mirror_start,
	// resets out, active high pulses/levels
	output logic                       por_reset,
	output logic                       hw_reset,
	output logic                       soft_reset,
	output logic                       cold_boot
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers for pad, gpio and rc clock

	logic [1:0]           pad_sync_r;
	logic [GPIO_PINS-1:0] gpio_s1_r;
	logic [GPIO_PINS-1:0] gpio_s2_r;
	logic [2:0]           rc_sync_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_sync_r <= 2'b00;
			gpio_s1_r  <= '0;
			gpio_s2_r  <= '0;
			rc_sync_r  <= 3'b000;
		end else begin
			pad_sync_r <= {pad_sync_r[0], reset_pad};
			gpio_s1_r  <= gpio_in;
			gpio_s2_r  <= gpio_s1_r;
			rc_sync_r  <= {rc_sync_r[1:0], low_freq_rc_clock};
		end
	end

	// rc edge from second and third stages only
	logic rc_tick;
	assign rc_tick = rc_sync_r[1] & ~rc_sync_r[2];

////////////////////////////////////////////////////////////////////////////////
// registers

	logic [31:0]            pmu_ctrl_r;
	logic [31:0]            sys_ctrl_r;
	logic [PIN_SEL_W-1:0]   pin_sel_r;
	logic                   por_pol_r;
	logic [POR_TIME_W-1:0]  por_time_r;
	logic                   deep_req_r;
	logic                   cpu_rst_req_r;
	logic [31:0]            retain_r;
	pmode_t                 mode_r;
	logic                   woke_r;
	logic [1:0]             last_rst_r;
	logic                   por_int_r;
	logic                   hw_int_r;
	logic                   soft_int_r;

	logic wr_en;
	assign wr_en = psel & penable & pwrite;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic hw_scope;
	logic any_scope;
	assign hw_scope  = por_int_r | hw_int_r;
	assign any_scope = hw_scope | soft_int_r;

	// por-only scope: time field returns to its reset value only on por
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_time_r <= POR_TIME_RESET;
		end else if (por_int_r) begin
			por_time_r <= POR_TIME_RESET;
		end else if (wr_en && paddr == OFS_POR_TIME && pstrb[0]) begin
			por_time_r <= pwdata[POR_TIME_W-1:0];
		end
	end

	// pin select clears on any reset; polarity kept until por
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sel_r <= '0;
			por_pol_r <= 1'b0;
		end else begin
			if (any_scope) begin
				pin_sel_r <= '0;
			end else if (wr_en && paddr == OFS_POR_PIN && pstrb[0]) begin
				pin_sel_r <= pwdata[PIN_SEL_W-1:0];
			end
			if (por_int_r) begin
				por_pol_r <= 1'b0;
			end else if (wr_en && paddr == OFS_POR_PIN && pstrb[0]) begin
				por_pol_r <= pwdata[POR_POL_BIT];
			end
		end
	end

	// por/hw scope: power and system control, retained across sleep unless the wake gives hw reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmu_ctrl_r <= PMU_CTRL_RESET;
			sys_ctrl_r <= '0;
			retain_r   <= '0;
		end else if (hw_scope) begin
			pmu_ctrl_r <= PMU_CTRL_RESET;
			sys_ctrl_r <= '0;
			retain_r   <= '0;
		end else begin
			if (wr_en && paddr == OFS_PMU_CTRL) begin
				pmu_ctrl_r <= merge(pmu_ctrl_r, pwdata, pstrb);
			end
			if (wr_en && paddr == OFS_SYS_CTRL) begin
				sys_ctrl_r <= merge(sys_ctrl_r, pwdata, pstrb);
			end else if (soft_int_r) begin
				sys_ctrl_r[SYS_SOFT_RST_BIT] <= 1'b0;
			end
			if (wr_en && paddr == OFS_RETAIN) begin
				retain_r <= merge(retain_r, pwdata, pstrb);
			end
		end
	end

	// any-reset scope
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_req_r    <= 1'b0;
			cpu_rst_req_r <= 1'b0;
		end else if (any_scope) begin
			deep_req_r    <= 1'b0;
			cpu_rst_req_r <= 1'b0;
		end else begin
			if (wr_en && paddr == OFS_CPU_SCR && pstrb[0]) begin
				deep_req_r <= pwdata[DEEP_SLEEP_BIT];
			end
			cpu_rst_req_r <= wr_en && paddr == OFS_CPU_AIRCR && pwdata == CPU_RESET_KEY;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// apb read path, zero wait

	logic addr_ok;
	assign addr_ok = paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == OFS_PMU_CTRL) begin
				prdata <= pmu_ctrl_r;
			end else if (paddr == OFS_SYS_CTRL) begin
				prdata <= sys_ctrl_r;
			end else if (paddr == OFS_POR_PIN) begin
				prdata <= {24'h00_0000, por_pol_r, 1'b0, pin_sel_r};
			end else if (paddr == OFS_POR_TIME) begin
				prdata <= {25'h000_0000, por_time_r};
			end else if (paddr == OFS_CPU_SCR) begin
				prdata <= {29'h0000_0000, deep_req_r, 2'b00};
			end else if (paddr == OFS_RETAIN) begin
				prdata <= retain_r;
			end else if (paddr == OFS_STATUS) begin
				prdata <= {24'h00_0000, last_rst_r, woke_r, 2'b00, mode_r};
			end else begin
				prdata <= '0;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// por timer: any source counts, release clears

	logic gpio_level;
	logic gpio_src;
	logic src_any;
	logic [PRESCALE_W-1:0] presc_r;
	logic [POR_TIME_W-1:0] cnt_r;
	logic                  pad_d_r;
	logic                  fired_r;
	logic                  expired_r;

	assign gpio_level = gpio_s2_r[pin_sel_r % GPIO_PINS];
	assign gpio_src   = (pin_sel_r != '0) && (gpio_level == por_pol_r);
	assign src_any    = pad_sync_r[1] | gpio_src;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r   <= '0;
			cnt_r     <= '0;
			expired_r <= 1'b0;
		end else if (!src_any) begin
			presc_r   <= '0;
			cnt_r     <= '0;
			expired_r <= 1'b0;
		end else if (rc_tick && !expired_r) begin
			presc_r <= presc_r + 1'b1;
			if (presc_r == '1) begin
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r + 1'b1 >= por_time_r) begin
					expired_r <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_d_r <= 1'b0;
			fired_r <= 1'b0;
		end else begin
			pad_d_r <= pad_sync_r[1];
			fired_r <= src_any & expired_r; // one por per held source
		end
	end

	assign rc_clock_enable = src_any | pmu_ctrl_r[0];

////////////////////////////////////////////////////////////////////////////////
// reset generation

	logic [4:0] soft_cnt_r;
	logic       wake_rst_req;
	logic       pad_release;

	// pad released before expiry gives hw reset
	assign pad_release = pad_d_r && !src_any && !expired_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_int_r  <= 1'b0;
			hw_int_r   <= 1'b0;
			soft_int_r <= 1'b0;
			soft_cnt_r <= '0;
			last_rst_r <= 2'b00;
		end else begin
			por_int_r <= src_any & expired_r & ~fired_r;
			hw_int_r  <= (pad_release | wake_rst_req) & ~hw_int_r;
			if (sys_ctrl_r[SYS_SOFT_RST_BIT] || cpu_rst_req_r) begin
				soft_int_r <= 1'b1;
				soft_cnt_r <= 5'(SOFT_RST_CYCLES);
			end else if (soft_cnt_r != '0) begin
				soft_cnt_r <= soft_cnt_r - 1'b1;
			end else begin
				soft_int_r <= 1'b0;
			end
			if (por_int_r) begin
				last_rst_r <= 2'd1;
			end else if (hw_int_r) begin
				last_rst_r <= 2'd2;
			end else if (soft_int_r) begin
				last_rst_r <= 2'd3;
			end
		end
	end

	assign por_reset  = por_int_r;
	assign hw_reset   = hw_int_r;
	assign soft_reset = soft_int_r;
	assign cold_boot  = por_int_r | hw_int_r;

////////////////////////////////////////////////////////////////////////////////
// power mode sequencer

	logic [RAM_CELLS-1:0] ram_ret;
	logic                 code_ret;
	assign ram_ret  = pmu_ctrl_r[PMU_RAM_RET_LSB +: PMU_RAM_RET_W];
	assign code_ret = sys_ctrl_r[SYS_CODE_RET_BIT];
	assign wake_rst_req = (mode_r == ST_WAKE) && (pmu_ctrl_r[PMU_RST_WAKE_BIT] || !woke_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= ST_ACTIVE;
			woke_r <= 1'b0;
		end else if (any_scope) begin
			mode_r <= ST_ACTIVE;
			woke_r <= 1'b0;
		end else begin
			case (mode_r)
				ST_ACTIVE: begin
					if (cpu_sleep_req && !deep_req_r) begin
						mode_r <= ST_SLEEP;
					end else if (cpu_sleep_req && ram_ret == '0) begin
						mode_r <= ST_DEEP_SLEEP;
					end else if (cpu_sleep_req) begin
						mode_r <= ST_EXT_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (wake_irq) begin
						mode_r <= ST_ACTIVE;
					end
				end
				ST_EXT_SLEEP: begin
					if (wake_irq) begin
						woke_r <= 1'b1;
						mode_r <= ST_WAKE;
					end
				end
				ST_DEEP_SLEEP: begin
					if (wake_irq) begin
						woke_r <= 1'b0;
						mode_r <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (code_ret) begin
						mode_r <= ST_ACTIVE;
					end else begin
						mode_r <= ST_MIRROR;
					end
				end
				ST_MIRROR: begin
					if (mirror_done) begin
						mode_r <= ST_ACTIVE;
					end
				end
				default: begin
					mode_r <= ST_ACTIVE;
				end
			endcase
		end
	end

	logic gated;
	assign gated = mode_r == ST_EXT_SLEEP || mode_r == ST_DEEP_SLEEP;

	// domain outputs registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_power_domain     <= 1'b1;
			peripheral_power_domain <= 1'b1;
			radio_power_domain      <= 1'b1;
			debug_power_domain      <= 1'b1;
			ram_cell_domains        <= '1;
			analog_enable           <= 1'b1;
			mirror_start            <= 1'b0;
		end else begin
			system_power_domain     <= !gated;
			debug_power_domain      <= !gated;
			analog_enable           <= !gated;
			peripheral_power_domain <= !gated && !pmu_ctrl_r[PMU_PER_OFF_BIT];
			radio_power_domain      <= !gated && !pmu_ctrl_r[PMU_RAD_OFF_BIT];
			if (mode_r == ST_DEEP_SLEEP) begin
				ram_cell_domains <= '0;
			end else if (mode_r == ST_EXT_SLEEP) begin
				ram_cell_domains <= ram_ret;
			end else begin
				ram_cell_domains <= '1;
			end
			mirror_start <= mode_r == ST_WAKE && !code_ret && !wake_rst_req;
		end
	end

endmodule
`default_nettype wire

// ### pmrc_checker.sv
// port checker for power_mode_reset_control
// assumes the single pclk domain and presetn reset
`timescale 1ns/1ps
`default_nettype none
module pmrc_checker
	import pmrc_pkg::*;
#(
	parameter int GPIO_PINS = 32
) (
	// clock, reset, apb
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	// events and outputs
	input wire logic                 wake_irq,
	input wire logic                 reset_pad,
	input wire logic                 system_power_domain,
	input wire logic                 debug_power_domain,
	input wire logic [RAM_CELLS-1:0] ram_cell_domains,
	input wire logic                 analog_enable,
	input wire logic                 rc_clock_enable,
	input wire logic                 mirror_start,
	input wire logic                 por_reset,
	input wire logic                 hw_reset,
	input wire logic                 soft_reset,
	input wire logic                 cold_boot
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_acc;
	assign wr_acc = psel && penable && pwrite;
	////////////////////////////////////////
	property p_cold; por_reset || hw_reset |-> cold_boot; endproperty
	a_cold: assert property (p_cold) else $error("cold boot missing");
	property p_auto_off; !system_power_domain |-> !debug_power_domain && !analog_enable; endproperty
	a_auto_off: assert property (p_auto_off) else $error("debug or analog left on");
	property p_deep_wake;
		$rose(wake_irq) && !system_power_domain && ram_cell_domains == 4'h0 |-> ##[1:40] hw_reset;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("no reset on deep wake");
	property p_key; wr_acc && paddr == OFS_CPU_AIRCR && pwdata == CPU_RESET_KEY |-> ##[1:3] soft_reset; endproperty
	a_key: assert property (p_key) else $error("key gave no soft reset");
	property p_sw_bit; wr_acc && paddr == OFS_SYS_CTRL && pwdata[SYS_SOFT_RST_BIT] |-> ##[1:3] soft_reset; endproperty
	a_sw_bit: assert property (p_sw_bit) else $error("bit gave no soft reset");
	property p_sw_len; $rose(soft_reset) |-> soft_reset[*8]; endproperty
	a_sw_len: assert property (p_sw_len) else $error("soft reset too short");
	property p_pad_rc; reset_pad[*4] |-> rc_clock_enable; endproperty
	a_pad_rc: assert property (p_pad_rc) else $error("rc not forced on");
	property p_por_held; por_reset |-> rc_clock_enable && !hw_reset; endproperty
	a_por_held: assert property (p_por_held) else $error("por without source");
	property p_mirror; mirror_start |-> system_power_domain && !cold_boot; endproperty
	a_mirror: assert property (p_mirror) else $error("mirror while unpowered");
	c_por: cover property (por_reset);
	c_hw: cover property (hw_reset);
	c_sw: cover property ($rose(soft_reset));
	c_mir: cover property (mirror_start);
endmodule
bind power_mode_reset_control pmrc_checker #(.GPIO_PINS(GPIO_PINS)) chk_u (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .wake_irq, .reset_pad, .system_power_domain,
	.debug_power_domain, .ram_cell_domains, .analog_enable, .rc_clock_enable, .mirror_start, .por_reset,
	.hw_reset, .soft_reset, .cold_boot
);
`default_nettype wire

// ### pmrc_far_side.sv
// far side model: reset pad, gpio bank, rc oscillator, mirror reply
// assumes the bench calls its tasks right after a pclk edge
`timescale 1ns/1ps
`default_nettype none
module pmrc_far_side (
	// from the block
	input  wire logic   pclk,
	input  wire logic   rc_clock_enable,
	input  wire logic   mirror_start,
	// to the block
	output logic        low_freq_rc_clock,
	output logic        mirror_done,
	output logic        reset_pad,
	output logic [31:0] gpio_in
);
	initial begin
		low_freq_rc_clock = 1'b0;
		mirror_done = 1'b0;
		reset_pad = 1'b0;
		gpio_in = 32'hffff_ffff;
	end
	// stops when not enabled, so a missing forced enable stalls the timer
	always #12 low_freq_rc_clock = rc_clock_enable ? ~low_freq_rc_clock : 1'b0;
	always @(posedge pclk) begin
		if (mirror_start) begin
			repeat (3) @(posedge pclk);
			mirror_done <= 1'b1;
			@(posedge pclk);
			mirror_done <= 1'b0;
		end
	end
	// pad has a pull-down: released reads low
	task automatic pad_set(input logic v);
		reset_pad <= v;
	endtask
	task automatic gpio_set(input int p, input logic v);
		gpio_in[p] <= v;
	endtask
endmodule
`default_nettype wire

// ### power_mode_reset_control_test.sv
// self-checking bench for power_mode_reset_control
// assumes pmrc_pkg, pmrc_far_side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control_test;
	import pmrc_pkg::*;
	// sleep rows: control, code kept, ram kept, mirrors (2 = not judged), wake resets
	localparam logic [31:0] RP [4] = '{32'h0000_0806, 32'h0000_0306, 32'h0000_0006, 32'h0000_010e};
	localparam logic        RS [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	localparam logic [3:0]  RR [4] = '{4'h8, 4'h3, 4'h0, 4'h1};
	localparam int          RM [4] = '{1, 0, 0, 0};
	localparam int          RH [4] = '{0, 0, 1, 1};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sw_q;
	logic [11:0] paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, gpio_in, rdv;
	logic        cpu_sleep_req, wake_irq, mirror_done, reset_pad, low_freq_rc_clock;
	logic        system_power_domain, peripheral_power_domain, radio_power_domain, debug_power_domain;
	logic [3:0]  ram_cell_domains;
	logic        analog_enable, rc_clock_enable, mirror_start, por_reset, hw_reset, soft_reset, cold_boot;
	logic [32:0] expq [$];
	logic [32:0] e;
	int          n_errors, checks, n_por, n_hw, n_sw, n_mir, cyc, seed;
	power_mode_reset_control dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.cpu_sleep_req, .wake_irq, .mirror_done, .reset_pad, .gpio_in, .low_freq_rc_clock,
		.system_power_domain, .peripheral_power_domain, .radio_power_domain, .debug_power_domain,
		.ram_cell_domains, .analog_enable, .rc_clock_enable, .mirror_start, .por_reset, .hw_reset,
		.soft_reset, .cold_boot
	);
	pmrc_far_side far_u (.pclk, .rc_clock_enable, .mirror_start, .low_freq_rc_clock, .mirror_done, .reset_pad,
		.gpio_in);
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;
	////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [32:0] ex, input logic [32:0] got);
		checks++;
		if (got !== ex) begin
			n_errors++;
			$display("BAD apb exp %h got %h", ex, got);
		end
	endtask
	task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic wait_cnt(ref int c, input int t, input int lim);
		for (int n = 0; n < lim && c < t; n++) @(posedge pclk);
		if (c < t) begin
			n_errors++;
			$display("BAD wait exp %0d got %0d", t, c);
			summarize();
		end
	endtask
	// every step starts just after an edge; the trailing idle edge keeps psel from two writes at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		if (n >= 50) wait_cnt(checks, checks + 1, 0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		expq.push_back(33'h0_0000_0000);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		expq.push_back({1'b0, ex});
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	task automatic kick(input logic wake);
		if (wake) wake_irq <= 1'b1;
		else cpu_sleep_req <= 1'b1;
		@(posedge pclk);
		wake_irq <= 1'b0;
		cpu_sleep_req <= 1'b0;
		repeat (40) @(posedge pclk);
	endtask
	task automatic rc_is(input logic ex);
		repeat (8) @(posedge pclk);
		chk_val("rc enable", 32'(ex), 32'(rc_clock_enable));
	endtask
	always @(posedge pclk) begin
		cyc++;
		sw_q <= soft_reset;
		if (por_reset === 1'b1) n_por++;
		if (hw_reset === 1'b1) n_hw++;
		if (mirror_start === 1'b1) n_mir++;
		if (soft_reset === 1'b1 && sw_q === 1'b0) n_sw++;
		if (psel && penable && pready) begin
			e = expq.pop_front();
			chk_rd(e, {pslverr, pwrite ? e[31:0] : prdata});
		end
	end
	////////////////////////////////////////
	initial begin
		logic [31:0] rnd;
		int          m0;
		int          h0;
		int          t0;
		seed = 26941;
		{presetn, psel, penable, pwrite, cpu_sleep_req, wake_irq} = 6'h00;
		paddr = 12'h000;
		pstrb = 4'hf;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_val("ram cells", 32'h0000_000f, 32'(ram_cell_domains));
		rd(OFS_POR_TIME, 32'(POR_TIME_RESET));
		rd(OFS_CPU_AIRCR, 32'h0000_0000);
		expq.push_back(33'h1_0000_0000);
		xfer(1'b0, 12'h040, 32'h0000_0000);
		wr(OFS_PMU_CTRL, 32'h0000_0100);
		wr(OFS_POR_PIN, 32'h0000_0085);
		wr(OFS_SYS_CTRL, 32'h0000_8000);
		wait_cnt(n_sw, 1, 20);
		repeat (24) @(posedge pclk);
		rd(OFS_PMU_CTRL, 32'h0000_0100);
		rd(OFS_POR_PIN, 32'h0000_0080);
		wr(OFS_CPU_AIRCR, CPU_RESET_KEY);
		wait_cnt(n_sw, 2, 20);
		repeat (24) @(posedge pclk);
		wr(OFS_CPU_AIRCR, 32'h05fa_0005);
		repeat (24) @(posedge pclk);
		chk_val("soft count", 32'h0000_0002, 32'(n_sw));
		wr(OFS_POR_TIME, 32'h0000_0005);
		far_u.pad_set(1'b1);
		repeat (100) @(posedge pclk);
		far_u.pad_set(1'b0);
		wait_cnt(n_hw, 1, 50);
		repeat (24) @(posedge pclk);
		chk_val("por count", 32'h0000_0000, 32'(n_por));
		rd(OFS_PMU_CTRL, 32'h0000_0000);
		rd(OFS_POR_TIME, 32'h0000_0005);
		wr(OFS_POR_PIN, 32'h0000_0005);
		rc_is(1'b0);
		far_u.gpio_set(5, 1'b0);
		rc_is(1'b1);
		far_u.gpio_set(5, 1'b1);
		wr(OFS_POR_PIN, 32'h0000_0000);
		far_u.gpio_set(0, 1'b0);
		rc_is(1'b0);
		far_u.gpio_set(0, 1'b1);
		wr(OFS_PMU_CTRL, 32'h0000_0002);
		wr(OFS_CPU_SCR, 32'h0000_0000);
		kick(1'b0);
		chk_val("plain sleep", 32'h0000_0005, 32'({system_power_domain, peripheral_power_domain, radio_power_domain}));
		kick(1'b1);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			wr(OFS_PMU_CTRL, 32'h0000_0f00);
			rd(OFS_PMU_CTRL, 32'h0000_0f00);
			wr(OFS_PMU_CTRL, (rdv & ~32'h0000_0f00) | RP[i]);
			wr(OFS_SYS_CTRL, 32'(RS[i]));
			wr(OFS_RETAIN, rnd);
			wr(OFS_CPU_SCR, 32'h0000_0004);
			kick(1'b0);
			chk_val("sleep domains", 32'h0000_0000, 32'({system_power_domain, debug_power_domain, analog_enable,
				peripheral_power_domain, radio_power_domain}));
			chk_val("ram cells", 32'(RR[i]), 32'(ram_cell_domains));
			m0 = n_mir;
			h0 = n_hw;
			kick(1'b1);
			chk_val("awake", 32'h0000_0001, 32'(system_power_domain));
			if (RM[i] != 2) chk_val("mirror", 32'(RM[i]), 32'(n_mir - m0));
			chk_val("wake reset", 32'(RH[i]), 32'(n_hw - h0));
			if (RH[i] == 0) begin
				rd(OFS_RETAIN, rnd);
				pstrb <= rnd[31:28];
				wr(OFS_RETAIN, ~rnd);
				pstrb <= 4'hf;
				rd(OFS_RETAIN, rnd ^ {{8{rnd[31]}}, {8{rnd[30]}}, {8{rnd[29]}}, {8{rnd[28]}}});
			end
		end
		far_u.gpio_set(5, 1'b0);
		wr(OFS_POR_TIME, 32'h0000_0001);
		wr(OFS_POR_PIN, 32'h0000_0085);
		t0 = cyc;
		far_u.gpio_set(5, 1'b1);
		repeat (1000) @(posedge pclk);
		far_u.pad_set(1'b1);
		repeat (1000) @(posedge pclk);
		far_u.gpio_set(5, 1'b0);
		wait_cnt(n_por, 1, 40000);
		far_u.pad_set(1'b0);
		chk_val("por delay", 32'h0000_0001, 32'(cyc - t0 >= 24560 && cyc - t0 <= 24700));
		repeat (24) @(posedge pclk);
		rd(OFS_POR_TIME, 32'(POR_TIME_RESET));
		rd(OFS_POR_PIN, 32'h0000_0000);
		summarize();
	end
endmodule
`default_nettype wire
